// ### core/cbtmb_top.sv
// CAN core clock select, bit timing and message buffer register block
//
// Chosen here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps

// Behaviour
// - Core clock from crystal or doubled clock
// - Select bit 0 crystal, 1 doubled clock
// - Without clock generator, always crystal
// - Quantum tick divides core clock by prescaler
// - Sync segment is one quantum
// - First segment programmable 4 to 16 quanta; the code takes field plus one, 1 to 16
// - Second segment programmable 2 to 8 quanta; the code takes field plus one, 1 to 8
// - Jump width programmable 1 to 4 quanta
// - Settings reach 10 kbps to 1 Mbps
// - Timing registers writable only in soft reset
// - First instance timer channel 4, second 5
// - Decodes a 128-byte register window
// - Background receive buffer visible only in test
// - Sixteen-byte slots at nibbles 2 and 4 to 7
// - Identifier, data, length, priority byte layout
// - Priority byte only in transmit slots
// - Buffer bytes have no reset value
// - Foreground receive buffer read-only
// - Transmit buffers readable and writable anytime
// - Extended identifier bit placement
// - Standard identifier bit placement
module cbtmb_top #(
   parameter bit CGM_PRESENT = 1'b1,
   parameter bit SECOND_INSTANCE = 1'b0
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [6:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   input wire logic i_crystal_osc_clock_en,
   input wire logic i_doubled_system_clock_en,
   input wire logic i_rx_pin,
   input wire logic [3:0] i_bg_load_addr,
   input wire logic [7:0] i_bg_load_data,
   input wire logic i_bg_load_wr,
   input wire logic i_bg_copy,
   input wire logic [1:0] i_tx_fetch_slot,
   input wire logic [3:0] i_tx_fetch_addr,
   output logic [7:0] o_tx_fetch_data,
   input wire logic i_frame_valid,
   input wire logic i_timer_link_en,
   output logic o_soft_reset_state,
   output logic o_time_quantum_tick,
   output logic o_bit_start,
   output logic o_sample_point,
   output logic o_sampled_bit,
   output logic o_timer_ch4,
   output logic o_timer_ch5
);

   // All control state of the block
   typedef struct packed {
      logic soft_reset;
      logic test_mode;
      logic clk_sel;
      logic [7:0] bt0;
      logic [7:0] bt1;
      logic [5:0] presc_cnt;
      cbtmb_pkg::cbtmb_phase_t phase;
      logic [4:0] tq_cnt;
      logic [4:0] seg1_len;
      logic [3:0] seg2_len;
      logic [2:0] rx_meta;
      logic rx_level;
      logic edge_pend;
      logic resync_done;
      logic tl_pend;
      logic tl_active;
      logic [7:0] rdata;
      logic [7:0] tx_data;
      logic tq_tick;
      logic bit_start;
      logic sample;
      logic sampled;
      logic ch4;
      logic ch5;
   } cbtmb_state_t;

   cbtmb_state_t st_reg;
   cbtmb_state_t st_next;

   // Message storage: no reset, contents undefined until written
   logic [7:0] fg_mem [16];
   logic [7:0] bg_mem [16];
   logic [7:0] tx_mem [cbtmb_pkg::NUM_TX][16];

   // Byte kept in a slot after masking the length byte and unused bytes
   function automatic logic [7:0] cbtmb_store_byte(input logic [3:0] pos,
                                                   input logic [7:0] d,
                                                   input logic is_tx);
      logic [7:0] r;
      r = d;
      if (pos == cbtmb_pkg::BYTE_LENGTH) begin
         r = d & cbtmb_pkg::LENGTH_MASK;
      end else if (pos == cbtmb_pkg::BYTE_PRIORITY) begin
         r = is_tx ? d : 8'h00;
      end else if (pos > cbtmb_pkg::BYTE_PRIORITY) begin
         r = 8'h00;
      end
      return r;
   endfunction

   // Smaller of two quantum counts
   function automatic logic [4:0] cbtmb_min5(input logic [4:0] a,
                                             input logic [4:0] b);
      return (a < b) ? a : b;
   endfunction

   logic [2:0] nib;
   logic [3:0] pos;
   logic tx_hit;
   logic [1:0] tx_idx;
   logic core_en;
   logic [4:0] sjw_len;
   logic fall_edge;

   // Address decode of the window
   assign nib = i_addr[6:4];
   assign pos = i_addr[3:0];
   assign tx_hit = (nib >= cbtmb_pkg::NIB_TX0) &&
                   (nib <= cbtmb_pkg::NIB_TX2);
   assign tx_idx = 2'(nib - cbtmb_pkg::NIB_TX0);

   // Core clock enable: crystal unless generator present and selected
   always_comb begin
      if (CGM_PRESENT && st_reg.clk_sel == cbtmb_pkg::CLKSEL_SYSTEM) begin
         core_en = i_doubled_system_clock_en;
      end else begin
         core_en = i_crystal_osc_clock_en;
      end
   end

   // Jump width in quanta, field plus one
   assign sjw_len = 5'(st_reg.bt0[cbtmb_pkg::BT0_SJW_LSB +: cbtmb_pkg::SJW_W])
                    + 5'h01;

   // Recessive to dominant transition of the filtered bus level
   assign fall_edge = st_reg.rx_level && (st_reg.rx_meta[1] == 1'b0) &&
                      (st_reg.rx_meta[2] == 1'b0);

   // Buffer writes: transmit slots from software, receive from the engine
   always_ff @(posedge i_clk) begin
      if (i_wr && tx_hit) begin
         tx_mem[tx_idx][pos] <= cbtmb_store_byte(pos, i_wdata, 1'b1);
      end
      if (i_bg_load_wr) begin
         bg_mem[i_bg_load_addr] <= cbtmb_store_byte(i_bg_load_addr,
                                                    i_bg_load_data, 1'b0);
      end
      if (i_bg_copy) begin
         fg_mem <= bg_mem;
      end
   end

   // Next state of registers, prescaler, bit timing and timer link
   always_comb begin
      st_next = st_reg;
      st_next.rdata = 8'h00;
      st_next.tq_tick = 1'b0;
      st_next.bit_start = 1'b0;
      st_next.sample = 1'b0;

      // Software writes to control and timing registers
      if (i_wr) begin
         unique case (i_addr)
            cbtmb_pkg::OFF_CTRL_ZERO: begin
               st_next.soft_reset = i_wdata[cbtmb_pkg::CTL0_SOFT_RESET];
               st_next.test_mode = i_wdata[cbtmb_pkg::CTL0_TEST_MODE];
            end
            cbtmb_pkg::OFF_MODULE_CONTROL_ONE: begin
               if (st_reg.soft_reset) begin
                  st_next.clk_sel = i_wdata[cbtmb_pkg::MC1_CLOCK_SELECT];
               end
            end
            cbtmb_pkg::OFF_BIT_TIMING_ZERO: begin
               if (st_reg.soft_reset) begin
                  st_next.bt0 = i_wdata;
               end
            end
            cbtmb_pkg::OFF_BIT_TIMING_ONE: begin
               if (st_reg.soft_reset) begin
                  st_next.bt1 = i_wdata;
               end
            end
            default: begin
               st_next.rdata = 8'h00;
            end
         endcase
      end

      // Read data, presented in the cycle after the strobe only
      if (i_rd) begin
         if (nib == cbtmb_pkg::NIB_FG_RX) begin
            st_next.rdata = cbtmb_store_byte(pos, fg_mem[pos], 1'b0);
         end else if (tx_hit) begin
            st_next.rdata = cbtmb_store_byte(pos, tx_mem[tx_idx][pos],
                                             1'b1);
         end else if (nib == cbtmb_pkg::NIB_BG_RX) begin
            st_next.rdata = st_reg.test_mode ?
               cbtmb_store_byte(pos, bg_mem[pos], 1'b0) : 8'h00;
         end else begin
            unique case (i_addr)
               cbtmb_pkg::OFF_CTRL_ZERO: begin
                  st_next.rdata[cbtmb_pkg::CTL0_SOFT_RESET] = st_reg.soft_reset;
                  st_next.rdata[cbtmb_pkg::CTL0_TEST_MODE] = st_reg.test_mode;
               end
               cbtmb_pkg::OFF_MODULE_CONTROL_ONE: begin
                  st_next.rdata[cbtmb_pkg::MC1_CLOCK_SELECT] = st_reg.clk_sel;
               end
               cbtmb_pkg::OFF_BIT_TIMING_ZERO: begin
                  st_next.rdata = st_reg.bt0;
               end
               cbtmb_pkg::OFF_BIT_TIMING_ONE: begin
                  st_next.rdata = st_reg.bt1;
               end
               cbtmb_pkg::OFF_STATUS: begin
                  st_next.rdata = {3'h0, st_reg.sampled, st_reg.rx_level,
                                   st_reg.tl_active, 2'(st_reg.phase)};
               end
               default: begin
                  st_next.rdata = 8'h00;
               end
            endcase
         end
      end

      // Transmit fetch port for the transmitter engine
      if (i_tx_fetch_slot < 2'(cbtmb_pkg::NUM_TX)) begin
         st_next.tx_data = tx_mem[i_tx_fetch_slot][i_tx_fetch_addr];
      end else begin
         st_next.tx_data = 8'h00;
      end

      // Bus input filter: level moves once stages two and three agree
      st_next.rx_meta = {st_reg.rx_meta[1:0], i_rx_pin};
      if (st_reg.rx_meta[1] == st_reg.rx_meta[2]) begin
         st_next.rx_level = st_reg.rx_meta[2];
      end
      if (fall_edge && !st_reg.resync_done) begin
         st_next.edge_pend = 1'b1;
      end

      // Timer link request, set wins over the clear at a bit start
      if (i_frame_valid) begin
         st_next.tl_pend = 1'b1;
      end

      if (st_reg.soft_reset) begin
         // Stopped: hold bit timing at the start of a bit
         st_next.presc_cnt = 6'h00;
         st_next.phase = cbtmb_pkg::PH_SYNC;
         st_next.tq_cnt = 5'h00;
         st_next.edge_pend = 1'b0;
         st_next.resync_done = 1'b0;
         st_next.tl_pend = 1'b0;
         st_next.tl_active = 1'b0;
      end else if (core_en) begin
         // Prescaler: quantum tick every field-plus-one core enables
         if (st_reg.presc_cnt ==
             st_reg.bt0[cbtmb_pkg::BT0_PRESC_LSB +: cbtmb_pkg::PRESC_W]) begin
            st_next.presc_cnt = 6'h00;
            st_next.tq_tick = 1'b1;
         end else begin
            st_next.presc_cnt = st_reg.presc_cnt + 6'h01;
         end
      end

      // Bit time sequencer, advanced once per quantum
      if (st_next.tq_tick) begin
         unique case (st_reg.phase)
            cbtmb_pkg::PH_SYNC: begin
               st_next.phase = cbtmb_pkg::PH_SEG1;
               st_next.tq_cnt = 5'h00;
               st_next.edge_pend = 1'b0;
               st_next.resync_done = 1'b0;
               st_next.seg1_len = 5'(st_reg.bt1[cbtmb_pkg::BT1_SEG1_LSB +:
                                  cbtmb_pkg::SEG1_W]) + 5'h01;
               st_next.seg2_len = 4'(st_reg.bt1[cbtmb_pkg::BT1_SEG2_LSB +:
                                  cbtmb_pkg::SEG2_W]) + 4'h1;
            end
            cbtmb_pkg::PH_SEG1: begin
               // Late edge lengthens the first segment by at most the jump
               if (st_reg.edge_pend) begin
                  st_next.seg1_len = st_reg.seg1_len +
                     cbtmb_min5(sjw_len, st_reg.tq_cnt + 5'h01);
                  st_next.edge_pend = 1'b0;
                  st_next.resync_done = 1'b1;
               end
               if (st_reg.tq_cnt + 5'h01 >= st_next.seg1_len) begin
                  st_next.phase = cbtmb_pkg::PH_SEG2;
                  st_next.tq_cnt = 5'h00;
                  st_next.sample = 1'b1;
                  st_next.sampled = st_reg.rx_level;
               end else begin
                  st_next.tq_cnt = st_reg.tq_cnt + 5'h01;
               end
            end
            cbtmb_pkg::PH_SEG2: begin
               // Early edge shortens the second segment by at most the jump
               if (st_reg.edge_pend &&
                   (5'(st_reg.seg2_len) - st_reg.tq_cnt <= sjw_len)) begin
                  st_next.phase = cbtmb_pkg::PH_SEG1;
                  st_next.tq_cnt = 5'h00;
                  st_next.bit_start = 1'b1;
                  st_next.edge_pend = 1'b0;
                  st_next.resync_done = 1'b1;
                  st_next.seg1_len = 5'(st_reg.bt1[cbtmb_pkg::BT1_SEG1_LSB +:
                                     cbtmb_pkg::SEG1_W]) + 5'h01;
               end else begin
                  if (st_reg.edge_pend) begin
                     st_next.seg2_len = st_reg.seg2_len - 4'(sjw_len);
                     st_next.edge_pend = 1'b0;
                     st_next.resync_done = 1'b1;
                  end
                  if (5'(st_next.seg2_len) <= st_reg.tq_cnt + 5'h01) begin
                     st_next.phase = cbtmb_pkg::PH_SYNC;
                     st_next.tq_cnt = 5'h00;
                     st_next.bit_start = 1'b1;
                  end else begin
                     st_next.tq_cnt = st_reg.tq_cnt + 5'h01;
                  end
               end
            end
            default: begin
               st_next.phase = cbtmb_pkg::PH_SYNC;
               st_next.tq_cnt = 5'h00;
            end
         endcase
      end

      // One bit time of timer pulse, begun at the next bit start
      if (st_next.bit_start) begin
         st_next.tl_active = st_reg.tl_pend;
         st_next.tl_pend = i_frame_valid;
      end
      st_next.ch4 = st_next.tl_active && i_timer_link_en &&
                    !SECOND_INSTANCE;
      st_next.ch5 = st_next.tl_active && i_timer_link_en &&
                    SECOND_INSTANCE;
   end

   // State register
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st_reg <= '0;
         st_reg.soft_reset <= cbtmb_pkg::CTL0_RESET[cbtmb_pkg::CTL0_SOFT_RESET];
         st_reg.clk_sel <= cbtmb_pkg::CLKSEL_CRYSTAL;
         st_reg.bt0 <= cbtmb_pkg::BT_RESET;
         st_reg.bt1 <= cbtmb_pkg::BT_RESET;
         st_reg.phase <= cbtmb_pkg::PH_SYNC;
         st_reg.rx_meta <= 3'h7;
         st_reg.rx_level <= 1'b1;
         st_reg.sampled <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   // Outputs straight from the state register
   assign o_rdata = st_reg.rdata;
   assign o_tx_fetch_data = st_reg.tx_data;
   assign o_soft_reset_state = st_reg.soft_reset;
   assign o_time_quantum_tick = st_reg.tq_tick;
   assign o_bit_start = st_reg.bit_start;
   assign o_sample_point = st_reg.sample;
   assign o_sampled_bit = st_reg.sampled;
   assign o_timer_ch4 = st_reg.ch4;
   assign o_timer_ch5 = st_reg.ch5;

endmodule

// ### core/cbtmb_pkg.sv
// Package of constants for the CAN bit timing and message buffer block
package cbtmb_pkg;
   // Window and slot geometry
   localparam int ADDR_W = 7;
   localparam int SLOT_W = 4;
   localparam int NUM_TX = 3;
   // Control registers within the window
   localparam logic [6:0] OFF_CTRL_ZERO = 7'h00;
   localparam logic [6:0] OFF_MODULE_CONTROL_ONE = 7'h01;
   localparam logic [6:0] OFF_BIT_TIMING_ZERO = 7'h02;
   localparam logic [6:0] OFF_BIT_TIMING_ONE = 7'h03;
   localparam logic [6:0] OFF_STATUS = 7'h04;
   // Upper address nibbles of the buffer slots
   localparam logic [2:0] NIB_BG_RX = 3'h2;
   localparam logic [2:0] NIB_FG_RX = 3'h4;
   localparam logic [2:0] NIB_TX0 = 3'h5;
   localparam logic [2:0] NIB_TX2 = 3'h7;
   // Byte positions inside a slot
   localparam logic [3:0] BYTE_LENGTH = 4'hC;
   localparam logic [3:0] BYTE_PRIORITY = 4'hD;
   localparam logic [7:0] LENGTH_MASK = 8'h0F;
   // Identifier bit positions
   localparam int IDB1_SRR = 4;
   localparam int IDB1_IDE = 3;
   localparam int IDB3_RTR_EXT = 0;
   localparam int IDB1_RTR_STD = 4;
   // Control register zero fields
   localparam int CTL0_SOFT_RESET = 0;
   localparam int CTL0_TEST_MODE = 7;
   localparam logic [7:0] CTL0_RESET = 8'h01;
   // Module control one fields
   localparam int MC1_CLOCK_SELECT = 0;
   // Bit timing zero: jump width [7:6], prescaler [5:0]
   localparam int BT0_SJW_LSB = 6;
   localparam int BT0_PRESC_LSB = 0;
   localparam int SJW_W = 2;
   localparam int PRESC_W = 6;
   // Bit timing one: second segment [6:4], first segment [3:0]
   localparam int BT1_SEG2_LSB = 4;
   localparam int BT1_SEG1_LSB = 0;
   localparam int SEG1_W = 4;
   localparam int SEG2_W = 3;
   localparam logic [7:0] BT_RESET = 8'h00;
   // Clock select encodings
   localparam logic CLKSEL_CRYSTAL = 1'b0;
   localparam logic CLKSEL_SYSTEM = 1'b1;
   // Timer channels of the two instances
   localparam int TIMER_CH_FIRST = 4;
   localparam int TIMER_CH_SECOND = 5;
   // Bit time phases
   typedef enum logic [1:0] {
      PH_SYNC,
      PH_SEG1,
      PH_SEG2
   } cbtmb_phase_t;
endpackage

// ### dv/cbtmb_props.sv
// Concurrent checks on the ports of the CAN timing and buffer block
`timescale 1ns/1ps
module cbtmb_props #(
   parameter bit SECOND_INSTANCE = 1'b0
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [6:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [7:0] o_rdata,
   input wire logic o_soft_reset_state,
   input wire logic o_bit_start,
   input wire logic o_sample_point,
   input wire logic o_timer_ch4,
   input wire logic o_timer_ch5
);
   logic test_q;
   logic sr_q;
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_n);
   // Shadow of the test mode and soft reset bits as software wrote them
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         test_q <= 1'b0;
         sr_q <= 1'b1;
      end else if (i_wr && i_addr == cbtmb_pkg::OFF_CTRL_ZERO) begin
         test_q <= i_wdata[cbtmb_pkg::CTL0_TEST_MODE];
         sr_q <= i_wdata[cbtmb_pkg::CTL0_SOFT_RESET];
      end
   end
   // Write into a transmit slot, then a read of the same byte
   sequence s_tx_wr;
      i_wr && i_addr[6:4] >= cbtmb_pkg::NIB_TX0 &&
         i_addr[3:0] < cbtmb_pkg::BYTE_LENGTH;
   endsequence
   sequence s_same_rd;
      i_rd && i_addr == $past(i_addr);
   endsequence
   a_rdata_idle: assert property (!i_rd |=> o_rdata == 8'h00)
      else $error("read data not zero outside a read");
   a_bg_hidden: assert property (i_rd && !test_q &&
      i_addr[6:4] == cbtmb_pkg::NIB_BG_RX |=> o_rdata == 8'h00)
      else $error("background buffer visible outside test mode");
   a_len_nibble: assert property (i_rd && i_addr[6] &&
      i_addr[3:0] == cbtmb_pkg::BYTE_LENGTH |=> o_rdata[7:4] == 4'h0)
      else $error("length byte upper bits not zero");
   a_unused_bytes: assert property (i_rd && i_addr[6] &&
      i_addr[3:1] == 3'h7 |=> o_rdata == 8'h00)
      else $error("unused slot byte not zero");
   a_rx_no_prio: assert property (i_rd && i_addr ==
      {cbtmb_pkg::NIB_FG_RX, cbtmb_pkg::BYTE_PRIORITY} |=> o_rdata == 8'h00)
      else $error("receive slot priority byte not zero");
   a_tx_readback: assert property (s_tx_wr ##1 s_same_rd
      |=> o_rdata == $past(i_wdata, 2))
      else $error("transmit byte read back differs");
   a_soft_follow: assert property (o_soft_reset_state != sr_q
      |=> o_soft_reset_state == sr_q)
      else $error("soft reset state does not follow its bit");
   a_soft_quiet: assert property (o_soft_reset_state [*2]
      |-> !o_bit_start && !o_sample_point)
      else $error("timing pulse while in soft reset");
   a_sample_apart: assert property (o_sample_point |-> !o_bit_start)
      else $error("sample point coincides with bit start");
   a_timer_chan: assert property
      ((SECOND_INSTANCE ? o_timer_ch4 : o_timer_ch5) == 1'b0)
      else $error("timer pulse on the wrong channel");
endmodule

bind cbtmb_top cbtmb_props #(.SECOND_INSTANCE(SECOND_INSTANCE)) u_props (
   .i_clk(i_clk),
   .i_rst_n(i_rst_n),
   .i_addr(i_addr),
   .i_wdata(i_wdata),
   .i_wr(i_wr),
   .i_rd(i_rd),
   .o_rdata(o_rdata),
   .o_soft_reset_state(o_soft_reset_state),
   .o_bit_start(o_bit_start),
   .o_sample_point(o_sample_point),
   .o_timer_ch4(o_timer_ch4),
   .o_timer_ch5(o_timer_ch5)
);

// ### dv/cbtmb_bus_node.sv
// Behavioural CAN bus node that pulls the receive line dominant on request
`timescale 1ns/1ps
module cbtmb_bus_node #(
   parameter int DOM_CYCLES = 40
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_send,
   output logic o_rx
);
   int cnt;
   // Dominant for a fixed span, recessive by the bus pull-up otherwise
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt <= 0;
      end else if (i_send) begin
         cnt <= DOM_CYCLES;
      end else if (cnt > 0) begin
         cnt <= cnt - 1;
      end
   end
   assign o_rx = (cnt == 0);
endmodule

// ### dv/cbtmb_bench.sv
// Self-checking testbench of the CAN timing and buffer block
`timescale 1ns/1ps
module cbtmb_bench;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [6:0] addr = 7'h00;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic xtal_en = 1'b0;
   logic dbl_en = 1'b0;
   logic [3:0] bg_addr = 4'h0;
   logic [7:0] bg_data = 8'h00;
   logic bg_wr = 1'b0;
   logic bg_copy = 1'b0;
   logic [1:0] f_slot = 2'h0;
   logic [3:0] f_addr = 4'h0;
   logic frame_ok = 1'b0;
   logic link_en = 1'b0;
   logic send = 1'b0;
   logic [7:0] rdata;
   logic [7:0] fdata;
   logic rx_pin, sr, tick, bstart, spt, sbit, ch4, ch5;
   logic bstart2, ch4_2, ch5_2;
   int n_fail = 0;
   int total_checks = 0;
   // 40 MHz clock
   initial begin
      forever #12.5 clk = ~clk;
   end
   cbtmb_top #(.CGM_PRESENT(1'b1), .SECOND_INSTANCE(1'b0)) i_dut (
      .i_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata),
      .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
      .i_crystal_osc_clock_en(xtal_en), .i_doubled_system_clock_en(dbl_en),
      .i_rx_pin(rx_pin), .i_bg_load_addr(bg_addr), .i_bg_load_data(bg_data),
      .i_bg_load_wr(bg_wr), .i_bg_copy(bg_copy), .i_tx_fetch_slot(f_slot),
      .i_tx_fetch_addr(f_addr), .o_tx_fetch_data(fdata),
      .i_frame_valid(frame_ok), .i_timer_link_en(link_en),
      .o_soft_reset_state(sr), .o_time_quantum_tick(tick),
      .o_bit_start(bstart), .o_sample_point(spt), .o_sampled_bit(sbit),
      .o_timer_ch4(ch4), .o_timer_ch5(ch5));
   // Second instance without clock generator, linked to channel five
   cbtmb_top #(.CGM_PRESENT(1'b0), .SECOND_INSTANCE(1'b1)) i_dut_xtal (
      .i_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata),
      .i_wr(wr), .i_rd(rd), .o_rdata(),
      .i_crystal_osc_clock_en(xtal_en), .i_doubled_system_clock_en(dbl_en),
      .i_rx_pin(rx_pin), .i_bg_load_addr(bg_addr), .i_bg_load_data(bg_data),
      .i_bg_load_wr(bg_wr), .i_bg_copy(bg_copy), .i_tx_fetch_slot(f_slot),
      .i_tx_fetch_addr(f_addr), .o_tx_fetch_data(),
      .i_frame_valid(frame_ok), .i_timer_link_en(link_en),
      .o_soft_reset_state(), .o_time_quantum_tick(),
      .o_bit_start(bstart2), .o_sample_point(), .o_sampled_bit(),
      .o_timer_ch4(ch4_2), .o_timer_ch5(ch5_2));
   cbtmb_bus_node i_node (.i_clk(clk), .i_rst_n(rst_n), .i_send(send),
      .o_rx(rx_pin));
   task automatic final_report;
      if (n_fail == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [7:0] exp,
         input logic [7:0] got);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      check("rdata", exp, rdata);
      @(posedge clk);
   endtask
   // Write then read the same byte on the very next cycle
   task automatic wr_rd(input logic [6:0] a, input logic [7:0] d,
         input logic [7:0] exp);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      check("readback", exp, rdata);
      @(posedge clk);
   endtask
   task automatic t_reset;
      rd_chk(7'h00, 8'h01);
      rd_chk(7'h02, 8'h00);
      rd_chk(7'h03, 8'h00);
      check("soft_reset", 8'h01, {7'h00, sr});
      wr_reg(7'h09, 8'hFF);
      rd_chk(7'h09, 8'h00);
      rd_chk(7'h30, 8'h00);
   endtask
   task automatic t_tx;
      logic [7:0] d;
      for (int s = 5; s < 8; s++) begin
         for (int b = 0; b < 16; b++) begin
            d = {1'b1, s[2:0], b[3:0]};
            if (b < 14) begin
               wr_rd({s[2:0], b[3:0]}, d, (b == 12) ? (d & 8'h0F) : d);
            end else begin
               rd_chk({s[2:0], b[3:0]}, 8'h00);
            end
         end
      end
      f_slot <= 2'h1;
      f_addr <= 4'h4;
      @(posedge clk);
      f_slot <= 2'h3;
      #1;
      check("fetch", 8'hE4, fdata);
      @(posedge clk);
      #1;
      check("fetch_none", 8'h00, fdata);
      @(posedge clk);
   endtask
   task automatic t_rx;
      logic [7:0] d;
      wr_reg(7'h00, 8'h81);
      for (int b = 0; b < 13; b++) begin
         d = (b == 12) ? 8'h0C : {~b[3:0], b[3:0]};
         bg_addr <= b[3:0];
         bg_data <= d;
         bg_wr <= 1'b1;
         @(posedge clk);
         bg_wr <= 1'b0;
         rd_chk({3'h2, b[3:0]}, d);
      end
      bg_copy <= 1'b1;
      @(posedge clk);
      bg_copy <= 1'b0;
      wr_reg(7'h40, 8'h55);
      rd_chk(7'h40, 8'hF0);
      rd_chk(7'h4C, 8'h0C);
      rd_chk(7'h4D, 8'h00);
      wr_reg(7'h00, 8'h01);
      rd_chk(7'h20, 8'h00);
   endtask
   // Measures bit length, sample position and quantum ticks, in cycles
   task automatic measure(input int eb, input int es, input int et,
         input int eb2);
      int n;
      int s;
      int b;
      int t;
      int b2;
      n = 0;
      s = 0;
      b = 0;
      t = 0;
      b2 = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (bstart !== 1'b1 && n < 100);
      if (eb != 0 && n == 100) begin
         check("bit_start_wait", 8'h01, 8'h00);
         final_report();
      end
      for (int k = 1; k <= 40 && b == 0; k++) begin
         @(posedge clk);
         #1;
         if (spt === 1'b1) s = k;
         if (tick === 1'b1) t++;
         if (bstart2 === 1'b1) b2 = k;
         if (bstart === 1'b1) b = k;
      end
      check("bit_len", eb[7:0], b[7:0]);
      check("sample_at", es[7:0], s[7:0]);
      check("tq_ticks", et[7:0], t[7:0]);
      check("bit_len_xtal", eb2[7:0], b2[7:0]);
      @(posedge clk);
   endtask
   task automatic t_row(input logic sel, input logic xe, input logic de,
         input logic [7:0] b0, input logic [7:0] b1, input int eb,
         input int es, input int et, input int eb2);
      wr_reg(7'h00, 8'h01);
      wr_reg(7'h01, {7'h00, sel});
      wr_reg(7'h02, b0);
      wr_reg(7'h03, b1);
      xtal_en <= xe;
      dbl_en <= de;
      wr_reg(7'h00, 8'h00);
      measure(eb, es, et, eb2);
   endtask
   task automatic t_link;
      int hi;
      logic c5;
      int hi2;
      logic c4;
      hi = 0;
      c5 = 1'b0;
      hi2 = 0;
      c4 = 1'b0;
      link_en <= 1'b1;
      frame_ok <= 1'b1;
      @(posedge clk);
      frame_ok <= 1'b0;
      repeat (40) begin
         @(posedge clk);
         #1;
         if (ch4 === 1'b1) hi++;
         if (ch5 !== 1'b0) c5 = 1'b1;
         if (ch5_2 === 1'b1) hi2++;
         if (ch4_2 !== 1'b0) c4 = 1'b1;
      end
      check("ch4_len", 8'h0E, hi[7:0]);
      check("ch5", 8'h00, {7'h00, c5});
      check("ch5_len", 8'h0E, hi2[7:0]);
      check("ch4_second", 8'h00, {7'h00, c4});
      @(posedge clk);
   endtask
   task automatic t_rxbit;
      send <= 1'b1;
      @(posedge clk);
      send <= 1'b0;
      repeat (30) @(posedge clk);
      #1;
      check("sampled_dom", 8'h00, {7'h00, sbit});
      repeat (40) @(posedge clk);
      #1;
      check("sampled_rec", 8'h01, {7'h00, sbit});
      @(posedge clk);
   endtask
   // Main sequence
   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      t_reset();
      t_tx();
      t_rx();
      t_row(1'b0, 1'b0, 1'b1, 8'h00, 8'h13, 0, 0, 0, 0);
      t_row(1'b1, 1'b0, 1'b1, 8'h00, 8'h13, 7, 5, 7, 0);
      t_row(1'b0, 1'b1, 1'b0, 8'h00, 8'h7F, 25, 17, 25, 25);
      t_row(1'b0, 1'b1, 1'b0, 8'hC1, 8'h13, 14, 10, 7, 14);
      wr_reg(7'h03, 8'h77);
      rd_chk(7'h03, 8'h13);
      t_link();
      t_rxbit();
      final_report();
   end
endmodule
